// file: hw/dcr_pkg.sv
// constants for the clock, dac and ram segment register bank
// assumes a serial host port with an 8-bit instruction, msb first
package dcr_pkg;
  // serial instruction layout
  localparam int unsigned ADDR_W   = 5;            // address bits in instruction
  localparam int unsigned DATA_W   = 48;           // widest register
  localparam int unsigned CNT_W    = 7;            // serial bit counter width
  localparam int unsigned READ_POS = 7;            // read flag in instruction
  localparam logic [6:0]  INSTR_BITS  = 7'h08;     // instruction length
  localparam logic [6:0]  NARROW_BITS = 7'h20;     // four byte register
  localparam logic [6:0]  WIDE_BITS   = 7'h30;     // six byte register

  // register addresses
  localparam logic [4:0] CFG_ADDR  = 5'h02;        // clock_pll_config
  localparam logic [4:0] DAC_ADDR  = 5'h03;        // dac_full_scale_control
  localparam logic [4:0] UPD_ADDR  = 5'h04;        // auto_update_interval
  localparam logic [4:0] SEG0_ADDR = 5'h05;        // ram_segment_rise
  localparam logic [4:0] SEG1_ADDR = 5'h06;        // ram_segment_fall

  // implemented bits and reset values
  localparam logic [31:0] CFG_MASK = 32'hc738c1fe;
  localparam logic [31:0] CFG_RST  = 32'h07384000;
  localparam logic [31:0] DAC_MASK = 32'h000000ff;
  localparam logic [31:0] DAC_RST  = 32'h000000ff;
  localparam logic [31:0] UPD_RST  = 32'h0fffffff;
  localparam logic [47:0] SEG_MASK = 48'hffff_ffc0_ffc7;
  localparam logic [47:0] SEG_RST  = 48'h0000_0000_0000;

  // clock_pll_config fields
  localparam int unsigned DRV_HI   = 31;
  localparam int unsigned DRV_LO   = 30;
  localparam int unsigned BAND_HI  = 26;
  localparam int unsigned BAND_LO  = 24;
  localparam int unsigned CP_HI    = 21;
  localparam int unsigned CP_LO    = 19;
  localparam int unsigned DIV_BYP  = 15;
  localparam int unsigned DIV_RSTN = 14;
  localparam int unsigned PLL_EN   = 8;
  localparam int unsigned N_HI     = 7;
  localparam int unsigned N_LO     = 1;
  // dac field
  localparam int unsigned FSC_HI   = 7;
  localparam int unsigned FSC_LO   = 0;
  // segment descriptor fields
  localparam int unsigned RATE_HI  = 47;
  localparam int unsigned RATE_LO  = 32;
  localparam int unsigned END_HI   = 31;
  localparam int unsigned END_LO   = 22;
  localparam int unsigned START_HI = 15;
  localparam int unsigned START_LO = 6;
  localparam int unsigned MODE_HI  = 2;
  localparam int unsigned MODE_LO  = 0;
endpackage : dcr_pkg

// file: hw/dcr_reg_if.sv
// carrier between the serial port engine and the register bank
// assumes one clock; rdata answers addr combinationally
`timescale 1ns/100ps
`default_nettype none
interface dcr_reg_if;
  logic        wr_stb;  // one-cycle write pulse
  logic [4:0]  addr;    // register address
  logic [47:0] wdata;   // write data, low bits for narrow registers
  logic [47:0] rdata;   // read data, zero above register width
  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface : dcr_reg_if
`default_nettype wire

// file: hw/dcr_pin_sync.sv
// three-stage synchroniser with agreement filter, one lane per bit
// assumes inputs asynchronous to sys_clk_i
`timescale 1ns/100ps
`default_nettype none
module dcr_pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // pins in, filtered levels out
  input  wire logic [WIDTH-1:0] pin_i,
  output var  logic [WIDTH-1:0] level_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic s1, s2, s3; // first stage feeds only the second
      // shift chain; level moves once stages two and three agree
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1 <= RST_VAL[g];
          s2 <= RST_VAL[g];
          s3 <= RST_VAL[g];
          level_o[g] <= RST_VAL[g];
        end else begin
          s1 <= pin_i[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            level_o[g] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule : dcr_pin_sync
`default_nettype wire

// file: hw/dcr_serial_port.sv
// serial host port engine: instruction byte then msb-first data
// assumes sclk, cs_n and sdio already synchronised to sys_clk_i
`timescale 1ns/100ps
`default_nettype none
module dcr_serial_port (
  // clock and reset
  input  wire logic   sys_clk_i,
  input  wire logic   rst_n_i,
  // synchronised pins
  input  wire logic   sclk_i,
  input  wire logic   cs_n_i,
  input  wire logic   sdio_i,
  // data pin drive
  output var  logic   sdio_o,
  output var  logic   sdio_oe_o,
  // register side
  dcr_reg_if.port     reg_if
);
  logic        sclk_q;   // previous sclk level
  logic [6:0]  bit_cnt;  // bits taken in this frame
  logic [7:0]  instr;    // instruction byte
  logic [47:0] shift;    // write data shifter
  logic [47:0] rd_shift; // read data shifter
  logic        load_rd;  // load read shifter next cycle

  // edge and phase decode
  wire       rise    = sclk_i & ~sclk_q & ~cs_n_i;
  wire       fall    = ~sclk_i & sclk_q & ~cs_n_i;
  wire       is_read = instr[dcr_pkg::READ_POS];
  wire       wide    = (reg_if.addr == dcr_pkg::SEG0_ADDR) ||
                       (reg_if.addr == dcr_pkg::SEG1_ADDR);
  wire [6:0] len     = wide ? dcr_pkg::WIDE_BITS : dcr_pkg::NARROW_BITS;
  wire [6:0] frame   = 7'(dcr_pkg::INSTR_BITS + len);
  wire [6:0] pad     = 7'(dcr_pkg::WIDE_BITS - len);
  wire       in_data = (bit_cnt >= dcr_pkg::INSTR_BITS) && (bit_cnt < frame);
  wire       last_wr = rise && !is_read && (bit_cnt == 7'(frame - 7'h01));

  assign reg_if.addr = instr[dcr_pkg::ADDR_W-1:0];

  // frame counter and input shifters
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q  <= 1'b0;
      bit_cnt <= 7'h00;
      instr   <= 8'h00;
      shift   <= 48'h0;
      load_rd <= 1'b0;
    end else begin
      sclk_q  <= sclk_i;
      load_rd <= rise && (bit_cnt == 7'(dcr_pkg::INSTR_BITS - 7'h01));
      if (cs_n_i) begin
        bit_cnt <= 7'h00; // deselect ends the frame
      end else if (rise && bit_cnt < frame) begin
        bit_cnt <= 7'(bit_cnt + 7'h01);
        if (bit_cnt < dcr_pkg::INSTR_BITS) begin
          instr <= {instr[6:0], sdio_i};
        end else begin
          shift <= {shift[46:0], sdio_i};
        end
      end
    end
  end

  // write strobe after the last data bit
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_if.wr_stb <= 1'b0;
      reg_if.wdata  <= 48'h0;
    end else begin
      reg_if.wr_stb <= last_wr;
      if (last_wr) begin
        reg_if.wdata <= {shift[46:0], sdio_i};
      end
    end
  end

  // read data leaves on falling sclk, msb first
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_shift  <= 48'h0;
      sdio_o    <= 1'b0;
      sdio_oe_o <= 1'b0;
    end else if (cs_n_i) begin
      sdio_oe_o <= 1'b0;
    end else if (load_rd && is_read) begin
      rd_shift <= reg_if.rdata << pad;
    end else if (fall && is_read) begin
      sdio_oe_o <= in_data;
      if (in_data) begin
        sdio_o   <= rd_shift[47];
        rd_shift <= {rd_shift[46:0], 1'b0};
      end
    end
  end
endmodule : dcr_serial_port
`default_nettype wire

// file: hw/dcr_regs.sv
// clock, dac and ram segment register bank behind the serial port
// assumes the enables of the other control words arrive on sys_clk_i
//
// Contract
// - clock config register at 0x02, four bytes
// - bits 31:30 reference output drive, reset 00
// - bits 26:24 oscillator band, reset 111
// - bits 21:19 charge pump current, reset 111
// - bit 15 divider bypass, reset uses divider
// - bit 14 divider reset, active low, reset 1
// - bit 8 pll enable, reset bypassed
// - bits 7:1 feedback divide modulus, reset 0
// - dac code at 0x03 bits 7:0, reset ff
// - update interval 0x04, four bytes, immediate
// - interval used only with enable; reset 0fffffff
// - segment 0 at 0x05, applied on trigger rise
// - segment 1 at 0x06, applied on trigger fall
// - descriptor bits 47:32 hold step rate
// - descriptor bits 31:22 hold end address
// - descriptor bits 15:6 hold start address
// - descriptor bits 2:0 hold playback mode
`timescale 1ns/100ps
`default_nettype none
module dcr_regs (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // serial host port pins
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        sdio_i,
  output var  logic        sdio_o,
  output var  logic        sdio_oe_o,
  // update and trigger pins
  input  wire logic        io_update_i,
  input  wire logic        ram_trigger_pin_i,
  // enables from the other control words
  input  wire logic        ram_enable_i,
  input  wire logic        auto_update_enable_i,
  // reference clock and pll controls
  output var  logic [1:0]  ref_out_drive_select_o,
  output var  logic [2:0]  oscillator_band_select_o,
  output var  logic [2:0]  charge_pump_current_o,
  output var  logic        ref_div_bypass_o,
  output var  logic        ref_div_reset_n_o,
  output var  logic        pll_enable_o,
  output var  logic [6:0]  pll_feedback_div_o,
  // dac current
  output var  logic [7:0]  dac_full_scale_code_o,
  // automatic update timer
  output var  logic        auto_update_active_o,
  output var  logic [31:0] auto_update_period_o,
  // applied ram segment
  output var  logic [15:0] ram_step_rate_o,
  output var  logic [9:0]  ram_end_addr_o,
  output var  logic [9:0]  ram_start_addr_o,
  output var  logic [2:0]  ram_playback_mode_o,
  output var  logic        ram_segment_sel_o,
  output var  logic        ram_segment_load_o
);
  dcr_reg_if reg_if ();

  // filtered pin levels
  logic sclk_s;     // serial clock
  logic cs_n_s;     // chip select, active low
  logic sdio_s;     // serial data in
  logic upd_s;      // update pin
  logic trig_s;     // ram trigger pin
  logic upd_q;      // update level one cycle back
  logic trig_q;     // trigger level one cycle back

  // stored registers, buffered copies hold software's view
  logic [31:0] cfg_buf;   // clock config as written
  logic [31:0] cfg_act;   // clock config driving the pll
  logic [31:0] dac_buf;   // dac code as written
  logic [31:0] upd_int;   // update interval, live
  logic [47:0] seg0;      // rise segment
  logic [47:0] seg1;      // fall segment
  logic [47:0] seg_act;   // segment handed to the ram engine

  // raw event pins, named before the synchroniser reads them
  wire trig_s_pin = ram_trigger_pin_i;
  wire upd_pin    = io_update_i;

  // pin synchroniser; cs_n idles high
  dcr_pin_sync #(
    .WIDTH   (5),
    .RST_VAL (5'h02)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     ({trig_s_pin, upd_pin, sdio_i, cs_n_i, sclk_i}),
    .level_o   ({trig_s, upd_s, sdio_s, cs_n_s, sclk_s})
  );
  // serial engine
  dcr_serial_port u_port (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .sclk_i    (sclk_s),
    .cs_n_i    (cs_n_s),
    .sdio_i    (sdio_s),
    .sdio_o    (sdio_o),
    .sdio_oe_o (sdio_oe_o),
    .reg_if    (reg_if.port)
  );

  // write decode
  wire wr_cfg  = reg_if.wr_stb && (reg_if.addr == dcr_pkg::CFG_ADDR);
  wire wr_dac  = reg_if.wr_stb && (reg_if.addr == dcr_pkg::DAC_ADDR);
  wire wr_upd  = reg_if.wr_stb && (reg_if.addr == dcr_pkg::UPD_ADDR);
  wire wr_seg0 = reg_if.wr_stb && (reg_if.addr == dcr_pkg::SEG0_ADDR);
  wire wr_seg1 = reg_if.wr_stb && (reg_if.addr == dcr_pkg::SEG1_ADDR);

  // pin events
  wire upd_rise  = upd_s & ~upd_q;
  wire trig_rise = trig_s & ~trig_q & ram_enable_i;
  wire trig_fall = ~trig_s & trig_q & ram_enable_i;

  // read mux; unmapped addresses read zero
  wire [47:0] rd_cfg  = (reg_if.addr == dcr_pkg::CFG_ADDR)  ? {16'h0, cfg_buf} : 48'h0;
  wire [47:0] rd_dac  = (reg_if.addr == dcr_pkg::DAC_ADDR)  ? {16'h0, dac_buf} : 48'h0;
  wire [47:0] rd_upd  = (reg_if.addr == dcr_pkg::UPD_ADDR)  ? {16'h0, upd_int} : 48'h0;
  wire [47:0] rd_seg0 = (reg_if.addr == dcr_pkg::SEG0_ADDR) ? seg0 : 48'h0;
  wire [47:0] rd_seg1 = (reg_if.addr == dcr_pkg::SEG1_ADDR) ? seg1 : 48'h0;
  assign reg_if.rdata = rd_cfg | rd_dac | rd_upd | rd_seg0 | rd_seg1;

  // edge history for the two event pins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_q  <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      upd_q  <= upd_s;
      trig_q <= trig_s;
    end
  end

  // buffered registers; only implemented bits are kept
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_buf <= dcr_pkg::CFG_RST;
      dac_buf <= dcr_pkg::DAC_RST;
    end else begin
      if (wr_cfg) begin
        cfg_buf <= reg_if.wdata[31:0] & dcr_pkg::CFG_MASK;
      end
      if (wr_dac) begin
        dac_buf <= reg_if.wdata[31:0] & dcr_pkg::DAC_MASK;
      end
    end
  end

  // buffered values reach the hardware at an update edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_act               <= dcr_pkg::CFG_RST;
      dac_full_scale_code_o <= dcr_pkg::DAC_RST[dcr_pkg::FSC_HI:dcr_pkg::FSC_LO];
    end else if (upd_rise) begin
      cfg_act               <= cfg_buf;
      dac_full_scale_code_o <= dac_buf[dcr_pkg::FSC_HI:dcr_pkg::FSC_LO];
    end
  end

  // clock config fields straight from the applied flops
  assign ref_out_drive_select_o   = cfg_act[dcr_pkg::DRV_HI:dcr_pkg::DRV_LO];
  assign oscillator_band_select_o = cfg_act[dcr_pkg::BAND_HI:dcr_pkg::BAND_LO];
  assign charge_pump_current_o    = cfg_act[dcr_pkg::CP_HI:dcr_pkg::CP_LO];
  assign ref_div_bypass_o         = cfg_act[dcr_pkg::DIV_BYP];
  assign ref_div_reset_n_o        = cfg_act[dcr_pkg::DIV_RSTN];
  assign pll_enable_o             = cfg_act[dcr_pkg::PLL_EN];
  assign pll_feedback_div_o       = cfg_act[dcr_pkg::N_HI:dcr_pkg::N_LO];

  // update interval, live without an update edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_int <= dcr_pkg::UPD_RST;
    end else if (wr_upd) begin
      upd_int <= reg_if.wdata[31:0];
    end
  end

  // timer sees the interval every cycle, enabled or not; active follows the enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_update_active_o <= 1'b0;
      auto_update_period_o <= dcr_pkg::UPD_RST;
    end else begin
      auto_update_active_o <= auto_update_enable_i;
      auto_update_period_o <= upd_int;
    end
  end

  // segment descriptors, stored at once
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg0 <= dcr_pkg::SEG_RST;
      seg1 <= dcr_pkg::SEG_RST;
    end else begin
      if (wr_seg0) begin
        seg0 <= reg_if.wdata & dcr_pkg::SEG_MASK;
      end
      if (wr_seg1) begin
        seg1 <= reg_if.wdata & dcr_pkg::SEG_MASK;
      end
    end
  end

  // trigger edges pick the descriptor for the ram engine
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_act            <= dcr_pkg::SEG_RST;
      ram_segment_sel_o  <= 1'b0;
      ram_segment_load_o <= 1'b0;
    end else begin
      ram_segment_load_o <= trig_rise | trig_fall;
      if (trig_rise) begin
        seg_act           <= seg0;
        ram_segment_sel_o <= 1'b0;
      end else if (trig_fall) begin
        seg_act           <= seg1;
        ram_segment_sel_o <= 1'b1;
      end
    end
  end

  // descriptor fields
  assign ram_step_rate_o     = seg_act[dcr_pkg::RATE_HI:dcr_pkg::RATE_LO];
  assign ram_end_addr_o      = seg_act[dcr_pkg::END_HI:dcr_pkg::END_LO];
  assign ram_start_addr_o    = seg_act[dcr_pkg::START_HI:dcr_pkg::START_LO];
  assign ram_playback_mode_o = seg_act[dcr_pkg::MODE_HI:dcr_pkg::MODE_LO];

  // checks on the bank
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // a single write strobe followed by a quiet cycle
  sequence cfg_write_s;
    wr_cfg ##1 !wr_cfg;
  endsequence

  sequence seg_rise_s;
    trig_s && !trig_q && ram_enable_i;
  endsequence

  sequence seg_fall_s;
    !trig_s && trig_q && ram_enable_i;
  endsequence

  cfg_hold_a : assert property (!upd_rise |=> $stable(cfg_act))
    else $error("clock config changed without update");
  cfg_apply_a : assert property (upd_rise |=>
                                 ref_out_drive_select_o == $past(cfg_buf[dcr_pkg::DRV_HI:dcr_pkg::DRV_LO]))
    else $error("drive select not applied at update");
  cfg_store_a : assert property (cfg_write_s |-> cfg_buf == ($past(reg_if.wdata[31:0]) & dcr_pkg::CFG_MASK))
    else $error("clock config write not stored");
  band_apply_a : assert property (upd_rise |=> oscillator_band_select_o == $past(cfg_buf[dcr_pkg::BAND_HI:dcr_pkg::BAND_LO])
                                  && charge_pump_current_o == $past(cfg_buf[dcr_pkg::CP_HI:dcr_pkg::CP_LO]))
    else $error("band or pump current not applied");
  dac_apply_a : assert property (upd_rise |=> dac_full_scale_code_o == $past(dac_buf[7:0]))
    else $error("dac code not applied at update");
  interval_live_a : assert property (wr_upd |=> ##1 auto_update_period_o == $past(reg_if.wdata[31:0], 2))
    else $error("interval not live two cycles after write");
  auto_gate_a : assert property (auto_update_active_o == $past(auto_update_enable_i))
    else $error("auto update enable not followed");
  seg_rise_a : assert property (seg_rise_s |=> seg_act == $past(seg0) && !ram_segment_sel_o && ram_segment_load_o)
    else $error("rise segment not applied");
  seg_fall_a : assert property (seg_fall_s |=> seg_act == $past(seg1) && ram_segment_sel_o && ram_segment_load_o)
    else $error("fall segment not applied");
  seg_idle_a : assert property (!ram_enable_i |=> $stable(seg_act) && !ram_segment_load_o)
    else $error("segment moved while ram disabled");
  reserved_zero_a : assert property (((cfg_buf & ~dcr_pkg::CFG_MASK) == 32'h0) &&
                                     ((seg0 & ~dcr_pkg::SEG_MASK) == 48'h0))
    else $error("reserved bits hold ones");
endmodule : dcr_regs
`default_nettype wire

// file: tb/dcr_host_model.sv
// host controller model driving the serial port of the register bank
// assumes sys_clk_i at 10 MHz; each sclk level is held for 8 system cycles
`timescale 1ns/100ps
`default_nettype none
module dcr_host_model (
  // system clock for pacing
  input  wire logic sys_clk_i,
  // serial pins toward the device
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic sdio_i,
  // device data drive
  input  wire logic sdio_o,
  input  wire logic sdio_oe_o
);
  logic host_d;  // host data level, toggled while released

  // the data wire: device wins while it drives, else the host level
  assign sdio_i = sdio_oe_o ? sdio_o : host_d;

  initial begin
    sclk   = 1'b0;
    cs_n   = 1'b1;
    host_d = 1'b0;
  end

  // one sclk half period, changes land on falling system edges
  task automatic half();
    repeat (8) @(negedge sys_clk_i);
  endtask : half

  // one frame: instruction byte then nb data bits, msb first
  task automatic xfer(input logic rd, input logic [4:0] a, input int nb, input logic [47:0] wd,
                      output logic [47:0] got);
    logic [55:0] sh;  // instruction and left-aligned data
    sh  = {rd, 2'b00, a, 48'(wd << (48 - nb))};
    got = '0;
    cs_n = 1'b0;
    half();
    for (int i = 0; i < 8 + nb; i++) begin
      sclk = 1'b0;
      // released during read data: wire toggles so stale values never match
      host_d = (rd && i >= 8) ? ~host_d : sh[55-i];
      half();
      sclk = 1'b1;
      if (i >= 8) begin
        got = {got[46:0], sdio_i};
      end
      half();
    end
    sclk = 1'b0;
    half();
    cs_n   = 1'b1;
    host_d = ~host_d;
    half();
  endtask : xfer
endmodule : dcr_host_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the clock, dac and ram segment register bank
// assumes the host model file is compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; $display("FAIL %0t got %h exp %h", $time, (got), (exp)); end end
module tb;
  // stimulus driven by the bench
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, io_update_i = 1'b0, ram_trigger_pin_i = 1'b0;
  logic ram_enable_i = 1'b0, auto_update_enable_i = 1'b0;
  // serial wires between host model and device
  wire logic sclk, cs_n, sdio_i, sdio_o, sdio_oe_o;
  // device outputs, plus the c, d, u stimulus words
  logic [1:0]  ref_out_drive_select_o;
  logic [2:0]  oscillator_band_select_o, charge_pump_current_o, ram_playback_mode_o;
  logic        ref_div_bypass_o, ref_div_reset_n_o, pll_enable_o, auto_update_active_o;
  logic [6:0]  pll_feedback_div_o;
  logic [7:0]  dac_full_scale_code_o;
  logic [31:0] auto_update_period_o, c, d, u;
  logic [15:0] ram_step_rate_o;
  logic [9:0]  ram_end_addr_o, ram_start_addr_o;
  logic        ram_segment_sel_o, ram_segment_load_o;
  // bench state
  int          n_mismatch = 0, n_tests = 0;
  logic [31:0] seed = 32'd39;
  logic [47:0] rv, s0, s1;
  logic [17:0] app_c = {2'b00, 3'b111, 3'b111, 1'b0, 1'b1, 1'b0, 7'h00};  // applied config, reset
  logic [7:0]  app_d = 8'hff;                                               // applied dac code, reset

  always #50 sys_clk_i = ~sys_clk_i;

  dcr_regs u_dcr_regs (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .io_update_i(io_update_i),
    .ram_trigger_pin_i(ram_trigger_pin_i), .ram_enable_i(ram_enable_i),
    .auto_update_enable_i(auto_update_enable_i), .ref_out_drive_select_o(ref_out_drive_select_o),
    .oscillator_band_select_o(oscillator_band_select_o), .charge_pump_current_o(charge_pump_current_o),
    .ref_div_bypass_o(ref_div_bypass_o), .ref_div_reset_n_o(ref_div_reset_n_o), .pll_enable_o(pll_enable_o),
    .pll_feedback_div_o(pll_feedback_div_o), .dac_full_scale_code_o(dac_full_scale_code_o),
    .auto_update_active_o(auto_update_active_o), .auto_update_period_o(auto_update_period_o),
    .ram_step_rate_o(ram_step_rate_o), .ram_end_addr_o(ram_end_addr_o), .ram_start_addr_o(ram_start_addr_o),
    .ram_playback_mode_o(ram_playback_mode_o), .ram_segment_sel_o(ram_segment_sel_o),
    .ram_segment_load_o(ram_segment_load_o));

  dcr_host_model u_host (.sys_clk_i(sys_clk_i), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o));

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected read-back: only implemented bits survive, unmapped reads zero
  function automatic logic [47:0] expect_rd(input logic [4:0] a, input logic [47:0] v);
    case (a)
      5'h02:        return {16'h0, v[31:0] & 32'hc738c1fe};
      5'h03:        return {40'h0, v[7:0]};
      5'h04:        return {16'h0, v[31:0]};
      5'h05, 5'h06: return v & 48'hffff_ffc0_ffc7;
      default:      return 48'h0;
    endcase
  endfunction : expect_rd

  // concatenated applied clock config outputs
  function automatic logic [17:0] cfg_of(input logic [31:0] v);
    return {v[31:30], v[26:24], v[21:19], v[15], v[14], v[8], v[7:1]};
  endfunction : cfg_of

  // write then read back one register
  task automatic rw(input logic [4:0] a, input logic [47:0] v);
    int nb;
    nb = (a == 5'h05 || a == 5'h06) ? 48 : 32;
    u_host.xfer(1'b0, a, nb, v, rv);
    u_host.xfer(1'b1, a, nb, 48'h0, rv);
    `CHK(rv, expect_rd(a, v))
  endtask : rw

  // move the trigger pin and watch for a load pulse
  task automatic trig(input logic lvl, input logic want);
    logic seen;
    seen = 1'b0;
    @(negedge sys_clk_i) ram_trigger_pin_i = lvl;
    repeat (15) begin
      @(negedge sys_clk_i);
      if (ram_segment_load_o === 1'b1) seen = 1'b1;
    end
    `CHK(seen, want)
  endtask : trig

  // verdict and end of run
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_mismatch++;
    conclude();
  end

  // main sequence
  initial begin
    logic [47:0] rst_tab [2:6];
    rst_tab = '{48'h07384000, 48'h000000ff, 48'h0fffffff, 48'h0, 48'h0};
    repeat (12) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    `CHK(cfg_of(32'h07384000), {ref_out_drive_select_o, oscillator_band_select_o, charge_pump_current_o,
         ref_div_bypass_o, ref_div_reset_n_o, pll_enable_o, pll_feedback_div_o})
    `CHK(dac_full_scale_code_o, 8'hff)
    `CHK(auto_update_period_o, 32'h0fffffff)
    // reset values through the port
    for (int i = 2; i <= 6; i++) begin
      u_host.xfer(1'b1, 5'(i), (i >= 5) ? 48 : 32, 48'h0, rv);
      `CHK(rv, rst_tab[i])
    end
    // buffered config and dac, corners then random
    for (int k = 0; k < 4; k++) begin
      c = (k == 0) ? 32'hffffffff : (k == 1) ? 32'h0 : rnd();
      d = (k == 0) ? 32'h0 : rnd();
      rw(5'h02, {16'h0, c});
      rw(5'h03, {16'h0, d});
      `CHK({ref_out_drive_select_o, oscillator_band_select_o, charge_pump_current_o, ref_div_bypass_o,
           ref_div_reset_n_o, pll_enable_o, pll_feedback_div_o}, app_c)
      `CHK(dac_full_scale_code_o, app_d)
      @(negedge sys_clk_i) io_update_i = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      io_update_i = 1'b0;
      repeat (8) @(negedge sys_clk_i);
      app_c = cfg_of(c);
      app_d = d[7:0];
      `CHK({ref_out_drive_select_o, oscillator_band_select_o, charge_pump_current_o, ref_div_bypass_o,
           ref_div_reset_n_o, pll_enable_o, pll_feedback_div_o}, app_c)
      `CHK(dac_full_scale_code_o, app_d)
    end
    // update interval takes effect without an update event
    u = rnd();
    rw(5'h04, {16'h0, u});
    `CHK(auto_update_period_o, u)
    auto_update_enable_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    `CHK(auto_update_active_o, 1'b1)
    auto_update_enable_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    `CHK(auto_update_active_o, 1'b0)
    // segment descriptors and unmapped places
    s0 = 48'({rnd(), rnd()});
    s1 = 48'({rnd(), rnd()});
    rw(5'h05, s0);
    rw(5'h06, s1);
    rw(5'h07, 48'({rnd(), rnd()}));
    trig(1'b1, 1'b0);
    trig(1'b0, 1'b0);
    ram_enable_i = 1'b1;
    trig(1'b1, 1'b1);
    `CHK({ram_step_rate_o, ram_end_addr_o, ram_start_addr_o, ram_playback_mode_o, ram_segment_sel_o},
         {s0[47:32], s0[31:22], s0[15:6], s0[2:0], 1'b0})
    trig(1'b0, 1'b1);
    `CHK({ram_step_rate_o, ram_end_addr_o, ram_start_addr_o, ram_playback_mode_o, ram_segment_sel_o},
         {s1[47:32], s1[31:22], s1[15:6], s1[2:0], 1'b1})
    conclude();
  end
endmodule : tb
`default_nettype wire
